// ### common/sptx_pkg.sv
// Summary of operation
// - LJ, I2S or RJ; 16/18/20/24-bit words
// - sample sync and data on clock rise
// - right-justified: sync high is left
// - right-justified MSB delay 16/14/12/8 clocks
// - right-justified LSB ends before next transition
// - I2S default; sync low is left
// - I2S MSB one clock after transition
// - left-justified: sync high left, no delay
package sptx_pkg;
   typedef enum logic [1:0] {
      SPTX_FMT_LJ,
      SPTX_FMT_I2S,
      SPTX_FMT_RJ
   } sptx_fmt_t;
   typedef enum logic [1:0] {
      SPTX_W16,
      SPTX_W18,
      SPTX_W20,
      SPTX_W24
   } sptx_width_t;
   localparam int SPTX_MAX_BITS = 24;
   localparam int SPTX_SLOTS = 32;
   localparam logic [5:0] SPTX_RJ_DLY_16 = 6'h10;
   localparam logic [5:0] SPTX_RJ_DLY_18 = 6'h0E;
   localparam logic [5:0] SPTX_RJ_DLY_20 = 6'h0C;
   localparam logic [5:0] SPTX_RJ_DLY_24 = 6'h08;
   localparam logic [5:0] SPTX_I2S_DLY = 6'h01;
   localparam logic [5:0] SPTX_LJ_DLY = 6'h00;
   localparam logic [2:0] SPTX_SYNC_RST = 3'h0;
endpackage

// ### src/sptx_skid_buf.sv
`timescale 1ns/1ps
// ==========================================
// two-entry buffer
module sptx_skid_buf #(
   parameter int W = 25
) (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   logic [W-1:0] mem_r [2];
   logic wp_r;
   logic rp_r;
   logic [1:0] cnt_r;
   wire push = in_valid_i && (cnt_r != 2'h2);
   wire pop = out_ready_i && (cnt_r != 2'h0);
   assign in_ready_o = (cnt_r != 2'h2);
   assign out_valid_o = (cnt_r != 2'h0);
   assign out_data_o = mem_r[rp_r];
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         if (push) wp_r <= ~wp_r;
         if (pop) rp_r <= ~rp_r;
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end
   always_ff @(posedge mclk_i) begin
      if (push) mem_r[wp_r] <= in_data_i;
   end
endmodule

// ### src/sptx_serial_in.sv
`timescale 1ns/1ps
// ==========================================
// serial audio input stage
module sptx_serial_in
   import sptx_pkg::*;
(
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic sclk_i,
   input wire logic fsync_i,
   input wire logic sdata_i,
   input wire sptx_fmt_t fmt_i,
   input wire sptx_width_t width_i,
   output logic word_valid_o,
   input wire logic word_ready_i,
   output logic [SPTX_MAX_BITS-1:0] word_data_o,
   output logic word_left_o,
   output logic overrun_o
);
   // ==========================================
   // pin synchronisers, three stages each
   logic [2:0] clk_s_r;
   logic [2:0] fs_s_r;
   logic [2:0] dat_s_r;
   logic clk_st_r;
   logic fs_st_r;
   logic dat_st_r;
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         clk_s_r <= SPTX_SYNC_RST;
         fs_s_r <= SPTX_SYNC_RST;
         dat_s_r <= SPTX_SYNC_RST;
         clk_st_r <= 1'b0;
         fs_st_r <= 1'b0;
         dat_st_r <= 1'b0;
      end else begin
         clk_s_r <= {clk_s_r[1:0], sclk_i};
         fs_s_r <= {fs_s_r[1:0], fsync_i};
         dat_s_r <= {dat_s_r[1:0], sdata_i};
         if (clk_s_r[1] == clk_s_r[2]) clk_st_r <= clk_s_r[2];
         if (fs_s_r[1] == fs_s_r[2]) fs_st_r <= fs_s_r[2];
         if (dat_s_r[1] == dat_s_r[2]) dat_st_r <= dat_s_r[2];
      end
   end
   wire clk_now = (clk_s_r[1] == clk_s_r[2]) ? clk_s_r[2] : clk_st_r;
   wire sclk_rise = clk_now && !clk_st_r;
   wire fs_now = (fs_s_r[1] == fs_s_r[2]) ? fs_s_r[2] : fs_st_r;
   wire dat_now = (dat_s_r[1] == dat_s_r[2]) ? dat_s_r[2] : dat_st_r;

   // ==========================================
   // format decode
   logic [5:0] nbits;
   logic [5:0] rj_dly;
   always_comb begin
      unique case (width_i)
         SPTX_W16: begin nbits = 6'd16; rj_dly = SPTX_RJ_DLY_16; end
         SPTX_W18: begin nbits = 6'd18; rj_dly = SPTX_RJ_DLY_18; end
         SPTX_W20: begin nbits = 6'd20; rj_dly = SPTX_RJ_DLY_20; end
         SPTX_W24: begin nbits = 6'd24; rj_dly = SPTX_RJ_DLY_24; end
      endcase
   end
   wire [5:0] msb_slot = (fmt_i == SPTX_FMT_RJ) ? rj_dly :
                         (fmt_i == SPTX_FMT_I2S) ? SPTX_I2S_DLY :
                         SPTX_LJ_DLY;
   // sync high is left except in I2S
   wire left_now = (fmt_i == SPTX_FMT_I2S) ? !fs_now : fs_now;

   // ==========================================
   // bit slot counter and shifter
   logic fs_prev_r;
   logic [5:0] slot_r;
   logic [5:0] got_r;
   logic [SPTX_MAX_BITS-1:0] sh_r;
   logic chan_left_r;
   logic emit_r;
   logic [SPTX_MAX_BITS-1:0] emit_data_r;
   logic emit_left_r;
   wire fs_edge = sclk_rise && (fs_now != fs_prev_r);
   wire [5:0] slot_cur = fs_edge ? 6'h00 : slot_r;
   // bit count restarts at the sync edge, so a slot-0 msb is not missed
   wire [5:0] got_cur = fs_edge ? 6'h00 : got_r;
   wire in_word = (slot_cur >= msb_slot) && (got_cur < nbits);
   wire take = sclk_rise && in_word;
   wire [SPTX_MAX_BITS-1:0] sh_nxt = {sh_r[SPTX_MAX_BITS-2:0], dat_now};
   wire last_bit = take && (got_cur == nbits - 6'h01);
   wire [4:0] pad = 5'(6'd24 - nbits);
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         fs_prev_r <= 1'b0;
         slot_r <= 6'h3F;
         got_r <= 6'd63;
         sh_r <= '0;
         chan_left_r <= 1'b1;
         emit_r <= 1'b0;
         emit_data_r <= '0;
         emit_left_r <= 1'b0;
      end else begin
         emit_r <= 1'b0;
         if (sclk_rise) begin
            fs_prev_r <= fs_now;
            slot_r <= (slot_cur == 6'h3F) ? slot_cur : slot_cur + 6'd1;
            if (fs_edge) begin
               got_r <= 6'd0;
               chan_left_r <= left_now;
            end
         end
         if (take) begin
            sh_r <= sh_nxt;
            got_r <= got_cur + 6'h01;
         end
         if (last_bit) begin
            emit_r <= 1'b1;
            emit_data_r <= sh_nxt << pad;
            emit_left_r <= fs_edge ? left_now : chan_left_r;
         end
      end
   end
   wire in_ready;
   wire out_valid;
   wire [SPTX_MAX_BITS:0] out_data;
   sptx_skid_buf #(.W(SPTX_MAX_BITS + 1)) u_buf (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .in_valid_i(emit_r),
      .in_ready_o(in_ready),
      .in_data_i({emit_left_r, emit_data_r}),
      .out_valid_o(out_valid),
      .out_ready_i(!word_valid_o || word_ready_i),
      .out_data_o(out_data)
   );
   // ==========================================
   // registered output stage
   wire out_take = out_valid && (!word_valid_o || word_ready_i);
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         word_valid_o <= 1'b0;
         word_data_o <= '0;
         word_left_o <= 1'b0;
         overrun_o <= 1'b0;
      end else begin
         if (out_take) begin
            word_valid_o <= 1'b1;
            word_data_o <= out_data[SPTX_MAX_BITS-1:0];
            word_left_o <= out_data[SPTX_MAX_BITS];
         end else if (word_ready_i) begin
            word_valid_o <= 1'b0;
         end
         overrun_o <= emit_r && !in_ready;
      end
   end
endmodule

// ### bench/sptx_src_model.sv
`timescale 1ns/1ps
// ====
// audio source, clock idle low between frames
module sptx_src_model import sptx_pkg::*; (
   output logic sclk_o = 0, fsync_o = 0, sdata_o = 0);
   task automatic send(input sptx_fmt_t f, sptx_width_t w, logic [23:0] l, r);
      int n, m, k;
      n = w == SPTX_W24 ? 24 : 16 + 2 * w;
      m = f == SPTX_FMT_LJ ? 0 : f == SPTX_FMT_I2S ? 1 : 32 - n;
      #7;
      for (int s = -1; s < 64; s++) begin
         k = s % 32 - m;
         fsync_o = (s >= 0 && s < 32) ^ (f == SPTX_FMT_I2S);
         sdata_o = k >= 0 && k < n ? (s < 32 ? l[23 - k] : r[23 - k]) : !sdata_o;
         #160 sclk_o = 1;
         #160 sclk_o = 0;
      end
   endtask
endmodule

// ### bench/sptx_serial_in_assertions.sv
`timescale 1ns/1ps
// ====
// port checks
module sptx_serial_in_assertions import sptx_pkg::*; (
   input wire logic mclk_i, srst_i, sclk_i, fsync_i, sdata_i, word_ready_i,
   input wire sptx_fmt_t fmt_i, input wire sptx_width_t width_i,
   input wire logic word_valid_o, word_left_o, overrun_o,
   input wire logic [SPTX_MAX_BITS-1:0] word_data_o);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   wire stall = word_valid_o && !word_ready_i;
   property p_rst; $fell(srst_i) |-> !word_valid_o && !overrun_o; endproperty
   a_rst: assert property (p_rst) else $error("rst");
   property p_hold; stall |=> word_valid_o && $stable(word_data_o); endproperty
   a_hold: assert property (p_hold) else $error("data");
   property p_side; stall |=> $stable(word_left_o); endproperty
   a_side: assert property (p_side) else $error("side");
   wire [SPTX_MAX_BITS-1:0] low_bits = word_data_o << (16 + 2 * width_i);
   property p_low; word_valid_o && width_i != SPTX_W24 |-> low_bits == '0; endproperty
   a_low: assert property (p_low) else $error("low");
   property p_chan; $rose(word_valid_o) && !$past(word_valid_o, 2) && fmt_i != SPTX_FMT_RJ
      |-> word_left_o == ((fmt_i == SPTX_FMT_I2S) ^ fsync_i); endproperty
   a_chan: assert property (p_chan) else $error("chan");
   property p_idle; $stable(sclk_i) [*8] ##1 !word_valid_o |=> !word_valid_o; endproperty
   a_idle: assert property (p_idle) else $error("idle");
   property p_ovr; overrun_o |=> !overrun_o; endproperty
   a_ovr: assert property (p_ovr) else $error("ovr");
   property p_drop; overrun_o |-> $past(word_valid_o); endproperty
   a_drop: assert property (p_drop) else $error("drop");
   c_ovr: cover property (overrun_o);
   c_rj: cover property (word_valid_o && fmt_i == SPTX_FMT_RJ);
   c_stall: cover property (stall);
endmodule
bind sptx_serial_in sptx_serial_in_assertions u_chk(.*);

// ### bench/sptx_serial_in_bench.sv
`timescale 1ns/1ps
// ====
module sptx_serial_in_bench import sptx_pkg::*; ;
   logic mclk_i = 0, srst_i = 1, rdy = 1, sc, fs, sd, v, lf, ov;
   logic [23:0] d;
   sptx_fmt_t fmt = SPTX_FMT_I2S;
   sptx_width_t wid = SPTX_W16;
   int err_total = 0, num_checks = 0, drops = 0;
   logic [24:0] q[$];
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_total++; \
   $display("[FAIL] %s %h %h", n, e, s); end end
   sptx_serial_in i_sptx_serial_in(.mclk_i, .srst_i, .sclk_i(sc), .fsync_i(fs), .sdata_i(sd),
      .fmt_i(fmt), .width_i(wid), .word_valid_o(v), .word_ready_i(rdy), .word_data_o(d),
      .word_left_o(lf), .overrun_o(ov));
   sptx_src_model i_sptx_src_model(.sclk_o(sc), .fsync_o(fs), .sdata_o(sd));
   initial forever #20 mclk_i = ~mclk_i;
   always @(posedge mclk_i) if (v === 1'b1 && rdy) q.push_back({lf, d});
   always @(posedge mclk_i) drops += ov === 1'b1;
   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wq(input int n);
      for (int t = 0; t < 500 && q.size() < n; t++) @(negedge mclk_i);
      if (q.size() < n) begin
         err_total++;
         report_and_stop();
      end
   endtask
   task automatic frame(input int f, w, k);
      @(negedge mclk_i) fmt = sptx_fmt_t'(f);
      wid = sptx_width_t'(w);
      i_sptx_src_model.send(fmt, wid, 24'hA53C96, 24'h5AC369);
      wq(2);
      `CHK("left", {1'b1, 24'hA53C96 >> k << k}, q[0])
      `CHK("right", {1'b0, 24'h5AC369 >> k << k}, q[1])
      q.delete();
   endtask
   task automatic s_formats;
      for (int f = 0; f < 3; f++)
         for (int w = 0; w < 4; w++) frame(f, w, w > 2 ? 0 : 8 - 2 * w);
   endtask
   task automatic s_stall;
      @(negedge mclk_i) rdy = 0;
      i_sptx_src_model.send(fmt, wid, 24'h123400, 24'hFEDC00);
      i_sptx_src_model.send(fmt, wid, 24'h0F0F00, 24'hF0F000);
      repeat (8) @(negedge mclk_i);
      `CHK("drops", 1, drops)
      @(negedge mclk_i) rdy = 1;
      wq(3);
      `CHK("first", {1'b1, 24'h123400}, q[0])
      `CHK("third", {1'b1, 24'h0F0F00}, q[2])
      q.delete();
   endtask
   initial begin
      repeat (16) @(negedge mclk_i);
      srst_i = 0;
      s_stall();
      s_formats();
      report_and_stop();
   end
endmodule
